// file: opc_panel.sv
// Operator panel control: selection, editing, run modes, presets, loader gate
//
// Contract
// (R1) Panel shows the selected processor register
// (R2) Bit switches edit the held panel value
// (R3) Halt shows memory word or addressed accumulator
// (R4) Loader switch gates top 64 words
// (R5) Loader open only if set at run
// (R6) A halt from run or stop clears the loader switch; a halt at the end of a phase or instruction step leaves it set
// (R7) Run locks all but halt, bits, clear
// (R8) Run lamp lit in run mode
// (R9) Processor preset: fetch, unprotect, clear parity/flag0/overflow
// (R10) Halt in run stops after current phase
// (R11) Halt press in halt steps one phase
// (R12) Halt lamp lit, dark while phase stepping
// (R13) I/O preset clears controls, sets flags
// (R14) I/O lamp lights on bit4 clear/press
// (R15) Auto restart: lamp held until program/press
// (R16) Instruction step runs one whole instruction
// (R17) Fetch lamp lit in fetch phase
// (R18) Edited value written back on other switch
// (R19) Selecting program counter forces fetch phase
// (R20) After halt memory word is selected
// (R21) Buttons synchronised into single-cycle press events
// (R22) Locked-out presses during run are dropped
module opc_panel (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [opc_pkg::NBTN-1:0] btn_i,
  input wire logic [opc_pkg::WORD_W-1:0] bit_sw_i,
  input wire opc_pkg::opc_regs_s regs_i,
  input wire logic fetch_i,
  input wire logic phase_end_i,
  input wire logic instr_end_i,
  input wire logic prog_halt_i,
  input wire logic [1:0] halt_acc_i,
  input wire logic ctrl4_clr_i,
  output logic proc_run_o,
  output opc_pkg::opc_cmd_s cmd_o,
  output logic wb_o,
  output opc_pkg::opc_sel_e wb_sel_o,
  output logic [opc_pkg::WORD_W-1:0] wb_data_o,
  output logic [opc_pkg::WORD_W-1:0] panel_o,
  output logic loader_open_o,
  output opc_pkg::opc_lamp_s lamp_o
);
  import opc_pkg::*;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Live value of a processor register
  function automatic logic [WORD_W-1:0] reg_val(opc_regs_s r, opc_sel_e s);
    logic [WORD_W-1:0] v;
    v = r.t;
    unique case (s)
      SEL_A: v = r.a;
      SEL_B: v = r.b;
      SEL_M: v = r.m;
      SEL_S: v = r.s;
      SEL_P: v = r.p;
      default: v = r.t;
    endcase
    return v;
  endfunction

  // ****************************************
  // Button synchronisers and press detect
  // ****************************************
  logic [NBTN+WORD_W-1:0] sy1_reg, sy2_reg, sy3_reg;  // Stage 1 feeds stage 2 only
  logic [NBTN+WORD_W-1:0] press;                      // One-cycle press events
  logic [NBTN-1:0] btn;                               // Control buttons
  logic [WORD_W-1:0] bitp;                            // Bit switch presses

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
      sy3_reg <= '0;
    end else if (ce_i) begin
      sy1_reg <= {bit_sw_i, btn_i};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  // Rising edge of the settled level, so holding a button acts once
  always_comb begin
    press = sy2_reg & ~sy3_reg;  // see (R21)
    btn = press[NBTN-1:0];
    bitp = press[NBTN+WORD_W-1:NBTN];
  end

  // ****************************************
  // Mode machine, selection and panel value
  // ****************************************
  opc_mode_e mode_reg, mode_next;
  opc_sel_e sel_reg, sel_next;
  logic [WORD_W-1:0] pan_reg, pan_next;   // Displayed or edited value
  logic dirty_reg, dirty_next;            // Operator edited the value
  logic ldsw_reg, ldsw_next;              // Loader access switch
  logic ldopen_reg, ldopen_next;          // Loader opened for this run
  logic iolamp_reg, iolamp_next;
  logic wb_reg, wb_next;
  opc_sel_e wbsel_reg, wbsel_next;
  logic [WORD_W-1:0] wbd_reg, wbd_next;
  opc_cmd_s cmd_reg, cmd_next;
  logic fetch_reg;
  logic auto_reg, auto_next;              // Automatic restart mode
  logic lampclr;                          // Software puts out I/O lamp
  logic halted;                           // Controls enabled
  logic sel_hit;
  opc_sel_e sel_btn;
  logic mode_hit;
  logic halt_evt;
  logic run_reg, run_next;                // Processor may run
  logic lrun_reg, lrun_next;              // Run lamp
  logic lhalt_reg, lhalt_next;            // Halt lamp

  always_comb begin
    mode_next = mode_reg;
    sel_next = sel_reg;
    pan_next = pan_reg;
    dirty_next = dirty_reg;
    ldsw_next = ldsw_reg;
    ldopen_next = ldopen_reg;
    iolamp_next = iolamp_reg;
    wb_next = 1'b0;
    wbsel_next = wbsel_reg;
    wbd_next = wbd_reg;
    cmd_next = '0;
    halt_evt = 1'b0;
    halted = (mode_reg == ST_HALT);
    // Locked-out presses are simply not seen while running
    sel_hit = halted && (btn[BTN_SEL_T:BTN_SEL_A] != 6'h00);  // see (R7) (R22)
    sel_btn = SEL_T;
    for (int i = BTN_SEL_T; i >= BTN_SEL_A; i--) begin
      if (btn[i]) begin
        sel_btn = opc_sel_e'(i[2:0]);
      end
    end
    mode_hit = halted && (btn[BTN_RUN] || btn[BTN_ISTEP] || btn[BTN_HALT]);
    // Mode transitions
    unique case (mode_reg)
      ST_HALT: begin
        if (btn[BTN_RUN]) begin
          mode_next = ST_RUN;
          ldopen_next = ldsw_reg;  // see (R5)
        end else if (btn[BTN_ISTEP]) begin
          mode_next = ST_ISTEP;  // see (R16)
        end else if (btn[BTN_HALT]) begin
          mode_next = ST_PSTEP;  // see (R11)
        end
      end
      ST_RUN: begin
        if (prog_halt_i) begin
          mode_next = ST_HALT;
          halt_evt = 1'b1;
        end else if (btn[BTN_HALT]) begin
          mode_next = ST_STOP;  // see (R10)
        end
      end
      ST_STOP: begin
        if (phase_end_i || prog_halt_i) begin
          mode_next = ST_HALT;  // see (R10)
          halt_evt = 1'b1;
        end
      end
      ST_PSTEP: begin
        if (phase_end_i) begin
          mode_next = ST_HALT;  // see (R11)
        end
      end
      ST_ISTEP: begin
        if (instr_end_i) begin
          mode_next = ST_HALT;  // see (R16)
        end
      end
      default: begin
        mode_next = ST_HALT;
      end
    endcase
    // Write back an edited value before leaving it
    if ((sel_hit || mode_hit) && dirty_reg) begin
      wb_next = 1'b1;  // see (R18)
      wbsel_next = sel_reg;
      wbd_next = pan_reg;
      dirty_next = 1'b0;
    end
    if (sel_hit) begin
      sel_next = sel_btn;
      dirty_next = 1'b0;
      cmd_next.force_fetch = (sel_btn == SEL_P);  // see (R19)
    end
    // Halt shows memory word unless an accumulator was addressed
    if (halt_evt) begin
      sel_next = (halt_acc_i == 2'h1) ? SEL_A : (halt_acc_i == 2'h2) ? SEL_B : SEL_T;  // see (R3) (R20)
      dirty_next = 1'b0;
      ldsw_next = 1'b0;  // see (R6)
      ldopen_next = 1'b0;  // see (R6)
    end
    // Panel tracks the live register until edited
    if (!dirty_next) begin
      pan_next = reg_val(regs_i, sel_next);  // see (R1)
    end
    if (btn[BTN_CLR] && !sel_hit && !halt_evt) begin
      pan_next = '0;
      dirty_next = 1'b1;
    end
    if (bitp != '0 && !sel_hit && !halt_evt) begin
      pan_next = (btn[BTN_CLR] ? '0 : pan_reg) ^ bitp;  // see (R2)
      dirty_next = 1'b1;
    end
    if (halted && btn[BTN_LOADER]) begin
      ldsw_next = ~ldsw_reg;  // see (R4)
    end
    if (halted && btn[BTN_IPRE]) begin
      cmd_next.force_fetch = 1'b1;  // see (R9)
      cmd_next.clr_mprot = 1'b1;
      cmd_next.clr_parity = 1'b1;
      cmd_next.clr_flag0 = 1'b1;
      cmd_next.clr_ovf = 1'b1;
    end
    // I/O preset lamp: a setting event wins over any clear
    if (lampclr || (auto_reg && halted && btn[BTN_XPRE] && iolamp_reg)) begin
      iolamp_next = 1'b0;  // see (R15)
    end else if (!auto_reg && btn[BTN_RUN] && halted) begin
      iolamp_next = 1'b0;
    end
    if (halted && btn[BTN_XPRE]) begin
      cmd_next.io_preset = 1'b1;  // see (R13)
      if (!(auto_reg && iolamp_reg)) begin
        iolamp_next = 1'b1;  // see (R14)
      end
    end
    if (ctrl4_clr_i) begin
      iolamp_next = 1'b1;  // see (R14)
    end
    // Mode decodes registered so the pins come straight from flops
    run_next = (mode_next != ST_HALT);
    lrun_next = (mode_next == ST_RUN) || (mode_next == ST_STOP);  // see (R8)
    lhalt_next = (mode_next == ST_HALT);  // see (R12)
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_reg <= ST_HALT;
      sel_reg <= SEL_T;
      pan_reg <= '0;
      dirty_reg <= 1'b0;
      ldsw_reg <= 1'b0;
      ldopen_reg <= 1'b0;
      iolamp_reg <= 1'b0;
      wb_reg <= 1'b0;
      wbsel_reg <= SEL_T;
      wbd_reg <= '0;
      cmd_reg <= '0;
      fetch_reg <= 1'b0;
      run_reg <= 1'b0;
      lrun_reg <= 1'b0;
      lhalt_reg <= 1'b1;
    end else if (ce_i) begin
      mode_reg <= mode_next;
      sel_reg <= sel_next;
      pan_reg <= pan_next;
      dirty_reg <= dirty_next;
      ldsw_reg <= ldsw_next;
      ldopen_reg <= ldopen_next;
      iolamp_reg <= iolamp_next;
      wb_reg <= wb_next;
      wbsel_reg <= wbsel_next;
      wbd_reg <= wbd_next;
      cmd_reg <= cmd_next;
      fetch_reg <= fetch_i;  // see (R17)
      run_reg <= run_next;
      lrun_reg <= lrun_next;
      lhalt_reg <= lhalt_next;
    end
  end

  // ****************************************
  // Outputs, all straight from flip-flops
  // ****************************************
  always_comb begin
    proc_run_o = run_reg;
    cmd_o = cmd_reg;
    wb_o = wb_reg;
    wb_sel_o = wbsel_reg;
    wb_data_o = wbd_reg;
    panel_o = pan_reg;
    loader_open_o = ldopen_reg;  // see (R4)
    lamp_o.run = lrun_reg;  // see (R8)
    lamp_o.halt = lhalt_reg;  // see (R12)
    lamp_o.fetch = fetch_reg;
    lamp_o.io_preset = iolamp_reg;
    lamp_o.loader = ldsw_reg;
  end

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  logic ph_wr_reg, ph_wr_next;       // Write data phase pending
  logic [7:0] ph_off_reg, ph_off_next;
  logic [31:0] rd_reg, rd_next;
  logic aph;

  always_comb begin
    aph = hsel_i && hready_i && htrans_i[1];
    ph_wr_next = aph && hwrite_i;
    ph_off_next = haddr_i[7:0];
    rd_next = rd_reg;
    auto_next = auto_reg;
    lampclr = 1'b0;
    // Read data registered at the address phase; unmapped reads zero
    if (aph && !hwrite_i) begin
      unique case (haddr_i[7:0])
        OFF_CTRL: rd_next = {31'h0, auto_reg};
        OFF_STAT: rd_next = {24'h0, ldopen_reg, ldsw_reg, iolamp_reg, fetch_reg,
                             dirty_reg, mode_reg};
        OFF_DISP: rd_next = {13'h0, sel_reg, pan_reg};
        default: rd_next = 32'h0;
      endcase
    end
    if (ph_wr_reg && ph_off_reg == OFF_CTRL) begin
      auto_next = hwdata_i[CTRL_AUTO_BIT];
      lampclr = hwdata_i[CTRL_LAMPCLR_BIT];  // see (R15)
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ph_wr_reg <= 1'b0;
      ph_off_reg <= 8'h00;
      rd_reg <= 32'h0;
      auto_reg <= CTRL_AUTO_RST;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      ph_wr_reg <= ph_wr_next;
      ph_off_reg <= ph_off_next;
      rd_reg <= rd_next;
      auto_reg <= auto_next;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  always_comb begin
    hrdata_o = rd_reg;
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_run_lock;
    @(posedge mclk_i) disable iff (rst_i) ce_i && !halted && !halt_evt |=> !wb_reg; // see (R7)
  endproperty
  a_run_lock: assert property (p_run_lock) else $error("write-back during run"); // see (R22)

  property p_run_lamp;
    @(posedge mclk_i) disable iff (rst_i) ce_i && halted && btn[BTN_RUN] |=> lamp_o.run;
  endproperty
  a_run_lamp: assert property (p_run_lamp) else $error("run lamp dark after run"); // see (R8)

  property p_loader_gate;
    @(posedge mclk_i) disable iff (rst_i)
      ce_i && halted && btn[BTN_RUN] |=> loader_open_o == $past(ldsw_reg);
  endproperty
  a_loader_gate: assert property (p_loader_gate) else $error("loader gate wrong"); // see (R5)

  property p_halt_clr;
    @(posedge mclk_i) disable iff (rst_i) ce_i && halt_evt |=> !ldsw_reg && !loader_open_o;
  endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("loader not cleared"); // see (R6)

  property p_halt_sel;
    @(posedge mclk_i) disable iff (rst_i)
      ce_i && halt_evt && halt_acc_i == 2'h0 |=> sel_reg == SEL_T && !dirty_reg;
  endproperty
  a_halt_sel: assert property (p_halt_sel) else $error("memory word not shown"); // see (R20)

  property p_preset;
    @(posedge mclk_i) disable iff (rst_i)
      ce_i && halted && btn[BTN_IPRE] |=> cmd_o.force_fetch && cmd_o.clr_ovf && cmd_o.clr_flag0;
  endproperty
  a_preset: assert property (p_preset) else $error("preset not issued"); // see (R9)

  property p_step;
    @(posedge mclk_i) disable iff (rst_i)
      ce_i && halted && btn[BTN_HALT] |=> !lamp_o.halt && proc_run_o;
  endproperty
  a_step: assert property (p_step) else $error("phase step not started"); // see (R12)

  property p_iolamp;
    @(posedge mclk_i) disable iff (rst_i) ce_i && ctrl4_clr_i |=> lamp_o.io_preset;
  endproperty
  a_iolamp: assert property (p_iolamp) else $error("I/O lamp dark"); // see (R14)

  property p_pfetch;
    @(posedge mclk_i) disable iff (rst_i)
      ce_i && sel_hit && sel_btn == SEL_P |=> cmd_o.force_fetch;
  endproperty
  a_pfetch: assert property (p_pfetch) else $error("no fetch on select"); // see (R19)

  c_run_stop: cover property (@(posedge mclk_i) mode_reg == ST_STOP ##[1:20] halted);
  c_wb: cover property (@(posedge mclk_i) wb_reg);
  c_istep: cover property (@(posedge mclk_i) mode_reg == ST_ISTEP ##[1:20] halted);

endmodule

// file: opc_pkg.sv
// Shared constants and types for the operator panel control block
package opc_pkg;

  // ****************************************
  // Widths and panel switch positions
  // ****************************************
  localparam int WORD_W = 16;       // Processor word width
  localparam int NBTN = 13;         // Panel push-buttons
  localparam int BTN_SEL_A = 0;     // Register select buttons, 0..5
  localparam int BTN_SEL_B = 1;
  localparam int BTN_SEL_M = 2;
  localparam int BTN_SEL_S = 3;
  localparam int BTN_SEL_P = 4;
  localparam int BTN_SEL_T = 5;
  localparam int BTN_RUN = 6;
  localparam int BTN_HALT = 7;      // Halt / single phase
  localparam int BTN_IPRE = 8;      // Processor preset
  localparam int BTN_XPRE = 9;      // I/O preset
  localparam int BTN_ISTEP = 10;    // instruction_single_step
  localparam int BTN_LOADER = 11;   // Loader access toggle
  localparam int BTN_CLR = 12;      // Clear display
  localparam int LOADER_WORDS = 64;     // Protected words at top of memory
  localparam int IO_PRESET_FIRST = 6;   // First select code hit by I/O preset
  localparam int IO_LAMP_CTRL_BIT = 4;  // Control bit whose clear lights lamp

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DISP = 8'h08;
  localparam int CTRL_AUTO_BIT = 0;     // Automatic restart mode
  localparam int CTRL_LAMPCLR_BIT = 1;  // Write 1: put out the I/O preset lamp
  localparam logic CTRL_AUTO_RST = 1'b0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SEL_A = 3'h0, SEL_B = 3'h1, SEL_M = 3'h2, SEL_S = 3'h3, SEL_P = 3'h4, SEL_T = 3'h5
  } opc_sel_e;

  typedef enum logic [2:0] {
    ST_HALT = 3'b000, ST_RUN = 3'b001, ST_STOP = 3'b011,
    ST_PSTEP = 3'b010, ST_ISTEP = 3'b110
  } opc_mode_e;

  typedef struct packed {
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
    logic [WORD_W-1:0] m;
    logic [WORD_W-1:0] s;
    logic [WORD_W-1:0] p;
    logic [WORD_W-1:0] t;
  } opc_regs_s;

  typedef struct packed {
    logic force_fetch;
    logic clr_mprot;
    logic clr_parity;
    logic clr_flag0;
    logic clr_ovf;
    logic io_preset;
  } opc_cmd_s;

  typedef struct packed {
    logic run;
    logic halt;
    logic fetch;
    logic io_preset;
    logic loader;
  } opc_lamp_s;

endpackage

// file: opc_proc_model.sv
// Behavioural model of the processor timing and control side of the panel
module opc_proc_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire opc_pkg::opc_cmd_s cmd_i,
  input wire logic wb_i,
  input wire opc_pkg::opc_sel_e wb_sel_i,
  input wire logic [opc_pkg::WORD_W-1:0] wb_data_i,
  input wire opc_pkg::opc_regs_s init_i,
  input wire logic [3:0] plen_i,
  output opc_pkg::opc_regs_s regs_o,
  output logic fetch_o,
  output logic phase_end_o,
  output logic instr_end_o
);
  import opc_pkg::*;
  logic [3:0] cnt_reg; // Cycles spent in the current phase
  logic exec_reg; // Low in fetch, high in execute
  // ****************************************
  // Phases advance only while allowed to run
  // ****************************************
  always_ff @(posedge mclk_i) begin
    phase_end_o <= 1'b0;
    instr_end_o <= 1'b0;
    if (rst_i) begin
      regs_o <= init_i;
      cnt_reg <= 4'h0;
      exec_reg <= 1'b0;
    end else begin
      if (wb_i) begin // Panel edits land in the chosen register
        case (wb_sel_i)
          SEL_A: regs_o.a <= wb_data_i;
          SEL_B: regs_o.b <= wb_data_i;
          SEL_M: regs_o.m <= wb_data_i;
          SEL_S: regs_o.s <= wb_data_i;
          SEL_P: regs_o.p <= wb_data_i;
          default: regs_o.t <= wb_data_i;
        endcase
      end
      if (cmd_i.force_fetch) begin // Preset restarts in fetch
        exec_reg <= 1'b0;
        cnt_reg <= 4'h0;
      end else if (run_i) begin // Slow or prompt by plen_i
        if (cnt_reg >= plen_i) begin
          cnt_reg <= 4'h0;
          phase_end_o <= 1'b1;
          exec_reg <= !exec_reg;
          instr_end_o <= exec_reg;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
  assign fetch_o = !exec_reg;
endmodule

// file: operator_panel_control_bench.sv
// Self-checking testbench for the operator panel control block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module operator_panel_control_bench;
  import opc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, rst_i = 1, hsel = 0, hwrite = 0, prog_halt = 0, ctrl4_clr = 0, ce = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, halt_acc = 0;
  logic [NBTN-1:0] btn = 0;
  logic [WORD_W-1:0] bits = 0, panel, ev, wb_data;
  logic [3:0] plen = 4'h1;
  logic [18:0] got;
  opc_regs_s init = '0, regs;
  opc_cmd_s cmd;
  opc_lamp_s lamp;
  opc_sel_e wb_sel;
  logic rdy, resp, run, wb, fetch, pend, iend, ldo;
  logic [18:0] expq[$]; // Expected pulses, oldest first
  int fail_count = 0, check_count = 0, k, n, i, pc, ic, dk;
  initial forever #4 mclk_i = ~mclk_i;
  opc_panel opc_panel_i (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp), .btn_i(btn),
    .bit_sw_i(bits), .regs_i(regs), .fetch_i(fetch), .phase_end_i(pend),
    .instr_end_i(iend), .prog_halt_i(prog_halt), .halt_acc_i(halt_acc),
    .ctrl4_clr_i(ctrl4_clr), .proc_run_o(run), .cmd_o(cmd), .wb_o(wb), .wb_sel_o(wb_sel),
    .wb_data_o(wb_data), .panel_o(panel), .loader_open_o(ldo), .lamp_o(lamp));
  opc_proc_model opc_proc_model_i (.mclk_i(mclk_i), .rst_i(rst_i), .run_i(run),
    .cmd_i(cmd), .wb_i(wb), .wb_sel_i(wb_sel), .wb_data_i(wb_data), .init_i(init),
    .plen_i(plen), .regs_o(regs), .fetch_o(fetch), .phase_end_o(pend), .instr_end_o(iend));
  // ****************************************
  // Closing report, the single exit point
  // ****************************************
  task end_sim;
    $display("checks %0d mismatches %0d pending %0d", check_count, fail_count, expq.size());
    if (fail_count == 0 && check_count > 0 && expq.size() == 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Bounded wait for the bus ready, a hang ends the run
  task wait_rdy;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      $display("CHECK FAILED t=%0t bus timeout", $time);
      end_sim;
    end
  endtask
  // One single AHB transfer; read data lands in rd
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  // Press and release one button, then let the action settle
  task press(input int b);
    @(posedge mclk_i) btn[b] <= 1'b1;
    @(posedge mclk_i) btn[b] <= 1'b0;
    repeat (5) @(posedge mclk_i);
  endtask
  // Step press while halted: count phases, instructions and dark lamp cycles
  task step(input int b);
    pc = 0;
    ic = 0;
    dk = 0;
    @(posedge mclk_i) btn[b] <= 1'b1;
    @(posedge mclk_i) btn[b] <= 1'b0;
    repeat (40) begin
      @(posedge mclk_i);
      pc += pend;
      ic += iend;
      dk += !lamp.halt;
    end
  endtask
  // Halt from run is only allowed a bounded time to land
  task wait_halt;
    for (n = 0; n < 60 && run; n++) @(posedge mclk_i);
    `CHK(run, 1'b0)
    if (run !== 1'b0) begin
      end_sim;
    end
  endtask
  task pulse_in(input logic ph);
    @(posedge mclk_i) begin prog_halt <= ph; ctrl4_clr <= !ph; end
    @(posedge mclk_i) begin prog_halt <= 1'b0; ctrl4_clr <= 1'b0; end
    repeat (4) @(posedge mclk_i);
  endtask
  // ****************************************
  // Monitor: every pulse must match the oldest note
  // ****************************************
  always @(posedge mclk_i) begin
    if (!rst_i && (wb || cmd != 6'h00)) begin
      got = wb ? {wb_sel, wb_data} : {3'h7, 10'h000, cmd};
      if (expq.size() == 0) begin
        fail_count++;
        $display("CHECK FAILED t=%0t unexpected pulse %h", $time, got);
      end else begin
        `CHK(got, expq.pop_front())
      end
    end
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    $display("CHECK FAILED t=%0t run timeout", $time);
    end_sim;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    n = $urandom(10512);
    init = {$urandom, $urandom, $urandom};
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    `CHK(lamp, 5'b01100)
    `CHK(panel, regs.t)
    $display("test reset done");
    for (i = 0; i < 6; i++) begin // Every select, program counter also fetches
      if (i == BTN_SEL_P) expq.push_back({3'h7, 10'h000, 6'h20});
      press(i);
      `CHK(panel, regs[(5-i)*16 +: 16])
    end
    press(BTN_SEL_A);
    k = $urandom_range(15, 0);
    @(posedge mclk_i) bits[k] <= 1'b1;
    @(posedge mclk_i) bits[k] <= 1'b0;
    repeat (5) @(posedge mclk_i);
    ev = regs.a ^ (16'h0001 << k);
    `CHK(panel, ev)
    expq.push_back({SEL_A, ev});
    press(BTN_SEL_B);
    `CHK({panel, regs.a}, {regs.b, ev})
    $display("test select and edit done");
    expq.push_back({3'h7, 10'h000, 6'h3e});
    press(BTN_IPRE);
    `CHK(lamp.fetch, 1'b1)
    expq.push_back({3'h7, 10'h000, 6'h01});
    press(BTN_XPRE);
    `CHK(lamp.io_preset, 1'b1)
    press(BTN_LOADER);
    `CHK(lamp.loader, 1'b1)
    press(BTN_RUN);
    `CHK({run, lamp.run, lamp.halt, ldo, lamp.io_preset}, 5'b11010)
    press(BTN_SEL_P);
    press(BTN_LOADER);
    press(BTN_IPRE);
    `CHK({run, lamp.loader}, 2'b11)
    bus(1'b0, {24'h0, OFF_STAT}, 32'h0);
    `CHK(rd[2:0], 3'b001)
    halt_acc <= 2'h1;
    pulse_in(1'b1);
    `CHK({run, lamp.halt, lamp.loader, ldo}, 4'b0100)
    `CHK(panel, regs.a)
    $display("test run and programmed halt done");
    halt_acc <= 2'h0;
    plen <= 4'h6;
    press(BTN_RUN);
    `CHK(ldo, 1'b0)
    press(BTN_HALT);
    wait_halt;
    bus(1'b0, {24'h0, OFF_DISP}, 32'h0);
    `CHK({lamp.halt, rd[18:16]}, {1'b1, SEL_T})
    plen <= 4'h2;
    step(BTN_HALT);
    `CHK({pc, dk > 0, run, lamp.halt}, {32'd1, 3'b101})
    `CHK(lamp.fetch, fetch)
    step(BTN_ISTEP);
    `CHK({ic, run}, {32'd1, 1'b0})
    $display("test halt and steps done");
    // A press made while the clock enable is low must leave no trace
    ce <= 1'b0;
    press(BTN_LOADER);
    ce <= 1'b1;
    repeat (4) @(posedge mclk_i);
    `CHK(lamp.loader, 1'b0)
    $display("test clock enable freeze done");
    bus(1'b1, {24'h0, OFF_CTRL}, 32'h1);
    bus(1'b0, {24'h0, OFF_CTRL}, 32'h0);
    `CHK(rd[1:0], 2'b01)
    bus(1'b0, 32'h40, 32'h0);
    `CHK(rd, 32'h0)
    pulse_in(1'b0);
    `CHK(lamp.io_preset, 1'b1)
    press(BTN_RUN);
    `CHK(lamp.io_preset, 1'b1)
    bus(1'b1, {24'h0, OFF_CTRL}, 32'h3);
    repeat (3) @(posedge mclk_i);
    `CHK(lamp.io_preset, 1'b0)
    press(BTN_HALT);
    wait_halt;
    pulse_in(1'b0);
    expq.push_back({3'h7, 10'h000, 6'h01});
    press(BTN_XPRE);
    `CHK(lamp.io_preset, 1'b0)
    $display("test automatic restart lamp done");
    end_sim;
  end
endmodule
